// *** hw/pwm_clock_polarity_config.sv ***
// Eight-channel pulse-width modulator with clock selection and polarity.
// Assumes an AXI4-Lite master on the same clock and synchronous reset.
//
// Operation
// RULE1 - Eight output pins, one per channel.
// RULE2 - Reserved bits read zero, ignore writes.
// RULE3 - Registers decoded at base plus offset.
// RULE4 - Polarity sets starting level, duty match flips.
// RULE5 - Polarity writable anytime; glitch tolerated.
// RULE6 - Absent channel bits ignore writes, read zero.
// RULE7 - Each channel picks one of four clocks.
// RULE8 - Channels 0,1,4,5: pair 0 picks A.
// RULE9 - Channels 2,3,6,7: pair 0 picks B.
// RULE10 - Clock select writable anytime; glitch tolerated.
// RULE11 - Pair picks family, select picks scaled member.
// RULE12 - Scaled A is A divided by twice scale.
// RULE13 - Scale zero means 256, divide by 512.
// RULE14 - Writing scale A reloads scale counter.
// RULE15 - Eight-bit counter, period and duty per channel.
// RULE16 - Enable at once, waveform from next clock.
// RULE17 - Three-bit prescalers derive clocks A and B.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module pwm_clock_polarity_config
  import pwm_cfg_pkg::*;
#(
  parameter logic [7:0] present_channels = 8'hFF,
  parameter int unsigned addr_width = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [addr_width-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [addr_width-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Waveform outputs
  output logic [num_channels-1:0] pwm_out
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  pwm_config_t cfg;
  logic [7:0] center_align;
  logic [7:0] control;
  logic [7:0] period [num_channels];
  logic [7:0] duty [num_channels];
  logic [7:0] counter [num_channels];

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  wr_state_t wr_state;
  logic have_aw;
  logic have_w;
  logic [addr_width-1:0] aw_hold;
  logic [31:0] w_hold;
  logic [3:0] s_hold;

  assign awready = (wr_state != st_resp) && !have_aw;
  assign wready = (wr_state != st_resp) && !have_w;

  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire aw_now = have_aw || aw_take;
  wire w_now = have_w || w_take;
  wire do_write = (wr_state != st_resp) && aw_now && w_now;
  wire [addr_width-1:0] wr_addr = have_aw ? aw_hold : awaddr;
  wire [31:0] wr_data = have_w ? w_hold : wdata;
  wire wr_lane0 = have_w ? s_hold[0] : wstrb[0];
  wire [7:0] wbyte = wr_data[7:0];

  function automatic logic mapped(input logic [addr_width-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    mapped = (o[1:0] == 2'h0) &&
      ((o <= off_scale_b_divider) ||
       ((o >= off_period_base) && (o < off_counter_base + 8'h20)));
  endfunction

  // Decoded byte offset; upper address bits above the block are ignored.
  wire [7:0] wo = 8'(wr_addr);
  wire wr_ok = mapped(wr_addr);
  wire wr_hit = do_write && wr_ok && wr_lane0; // RULE3

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_state <= st_idle;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_hold <= '0;
      w_hold <= '0;
      s_hold <= '0;
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end else begin
      if (aw_take) aw_hold <= awaddr;
      if (w_take) begin
        w_hold <= wdata;
        s_hold <= wstrb;
      end
      if (do_write) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? resp_okay : resp_slverr;
        wr_state <= st_resp;
      end else begin
        if (aw_take) have_aw <= 1'b1;
        if (w_take) have_w <= 1'b1;
        if (aw_take || w_take) wr_state <= st_hold;
        if (bvalid && bready) begin
          bvalid <= 1'b0;
          wr_state <= st_idle;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  wire [7:0] wchan = wbyte & present_channels; // RULE6

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg <= '0;
      center_align <= reset_zero;
      control <= reset_zero;
    end else if (wr_hit) begin
      unique case (wo)
        off_channel_enable: cfg.enable <= wchan;
        off_output_polarity: cfg.polarity <= wchan; // RULE5
        off_clock_source_select: cfg.clk_select <= wchan; // RULE10
        off_clock_pair_select: cfg.pair_select <= wchan;
        off_prescale_select: cfg.prescale <= wbyte & prescale_mask; // RULE2
        off_center_align_enable: center_align <= wchan;
        off_modulator_control: control <= wbyte & control_mask; // RULE2
        off_scale_a_divider: cfg.scale_a <= wbyte;
        off_scale_b_divider: cfg.scale_b <= wbyte;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock A and B prescalers from the bus clock
  // ----------------------------------------------------------------
  logic [7:0] pre_count;
  logic [7:0] pre_prev;
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_count <= reset_zero;
      pre_prev <= reset_zero;
    end else begin
      pre_count <= pre_count + 8'h01;
      pre_prev <= pre_count;
    end
  end

  // A tick marks each rising edge of the divided clock.
  function automatic logic pre_tick(input logic [2:0] sel,
                                    input logic [7:0] now,
                                    input logic [7:0] prev);
    pre_tick = (sel == 3'h0) ? 1'b1 : (now[sel-1] && !prev[sel-1]);
  endfunction

  wire [2:0] prescale_a_field = cfg.prescale[prescale_a_lsb +: 3];
  wire [2:0] prescale_b_field = cfg.prescale[prescale_b_lsb +: 3];
  wire tick_a = pre_tick(prescale_a_field, pre_count, pre_prev); // RULE17
  wire tick_b = pre_tick(prescale_b_field, pre_count, pre_prev); // RULE17

  // ----------------------------------------------------------------
  // Scaled clocks: toggle every scale count, so the divide is twice it
  // ----------------------------------------------------------------
  logic [7:0] scale_a_cnt;
  logic [7:0] scale_b_cnt;
  logic half_a;
  logic half_b;
  wire reload_a = wr_hit && (wo == off_scale_a_divider);
  wire reload_b = wr_hit && (wo == off_scale_b_divider);
  wire wrap_a = tick_a && (scale_a_cnt == 8'h01);
  wire wrap_b = tick_b && (scale_b_cnt == 8'h01);
  wire scaled_clock_a = wrap_a && !half_a;
  wire scaled_clock_b = wrap_b && !half_b;

  always_ff @(posedge clock) begin
    if (rst) begin
      scale_a_cnt <= reset_zero;
      scale_b_cnt <= reset_zero;
      half_a <= 1'b0;
      half_b <= 1'b0;
    end else begin
      if (reload_a) begin
        scale_a_cnt <= wbyte; // RULE14
      end else if (wrap_a) begin
        scale_a_cnt <= cfg.scale_a; // RULE12
        half_a <= !half_a;
      end else if (tick_a) begin
        scale_a_cnt <= scale_a_cnt - 8'h01; // RULE13
      end
      if (reload_b) begin
        scale_b_cnt <= wbyte;
      end else if (wrap_b) begin
        scale_b_cnt <= cfg.scale_b;
        half_b <= !half_b;
      end else if (tick_b) begin
        scale_b_cnt <= scale_b_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel clock choice and timers
  // ----------------------------------------------------------------
  // Pair bit picks the family with per-channel sense; select picks scaled.
  wire [7:0] use_a = cfg.pair_select ^ a_family_at_zero; // RULE8 RULE9
  logic [7:0] ch_tick;
  logic [7:0] run;

  always_comb begin
    for (int i = 0; i < num_channels; i++) begin
      unique case ({use_a[i], cfg.clk_select[i]}) // RULE7 RULE11
        2'b10: ch_tick[i] = tick_a;
        2'b11: ch_tick[i] = scaled_clock_a;
        2'b00: ch_tick[i] = tick_b;
        2'b01: ch_tick[i] = scaled_clock_b;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      run <= reset_zero;
      pwm_out <= reset_zero;
      for (int i = 0; i < num_channels; i++) begin
        period[i] <= reset_period;
        duty[i] <= reset_duty;
        counter[i] <= reset_zero;
      end
    end else begin
      for (int i = 0; i < num_channels; i++) begin
        if (wr_hit && wo == off_period_base + 8'(4 * i) &&
            present_channels[i]) period[i] <= wbyte;
        if (wr_hit && wo == off_duty_base + 8'(4 * i) &&
            present_channels[i]) duty[i] <= wbyte;
        if (!cfg.enable[i]) begin
          run[i] <= 1'b0;
          counter[i] <= reset_zero;
          pwm_out[i] <= cfg.polarity[i]; // RULE1
        end else if (ch_tick[i]) begin
          run[i] <= 1'b1; // RULE16
          if (!run[i] || counter[i] >= period[i] - 8'h01) begin
            counter[i] <= reset_zero; // RULE15
            pwm_out[i] <= (duty[i] == 8'h00) ^ cfg.polarity[i]; // RULE4
          end else begin
            counter[i] <= counter[i] + 8'h01;
            if (counter[i] + 8'h01 == duty[i])
              pwm_out[i] <= !cfg.polarity[i]; // RULE4
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire [7:0] ro = 8'(araddr);
  wire [2:0] rd_ch = ro[4:2];
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = reset_zero;
    unique case (ro)
      off_channel_enable: rd_byte = cfg.enable;
      off_output_polarity: rd_byte = cfg.polarity;
      off_clock_source_select: rd_byte = cfg.clk_select;
      off_clock_pair_select: rd_byte = cfg.pair_select;
      off_prescale_select: rd_byte = cfg.prescale;
      off_center_align_enable: rd_byte = center_align;
      off_modulator_control: rd_byte = control;
      off_scale_a_divider: rd_byte = cfg.scale_a;
      off_scale_b_divider: rd_byte = cfg.scale_b;
      default: begin
        if (ro >= off_counter_base) rd_byte = counter[rd_ch];
        else if (ro >= off_duty_base) rd_byte = duty[rd_ch];
        else if (ro >= off_period_base) rd_byte = period[rd_ch];
      end
    endcase
  end

  assign arready = !rvalid;

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= resp_okay;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, mapped(araddr) ? rd_byte : 8'h00}; // RULE2
      rresp <= mapped(araddr) ? resp_okay : resp_slverr;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** hw/pwm_cfg_pkg.sv ***
// Constants and types shared by the eight-channel modulator block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package pwm_cfg_pkg;

  localparam int unsigned num_channels = 8;
  localparam int unsigned reg_width = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] off_channel_enable = 8'h00;
  localparam logic [7:0] off_output_polarity = 8'h04;
  localparam logic [7:0] off_clock_source_select = 8'h08;
  localparam logic [7:0] off_prescale_select = 8'h0C;
  localparam logic [7:0] off_center_align_enable = 8'h10;
  localparam logic [7:0] off_modulator_control = 8'h14;
  localparam logic [7:0] off_scale_a_divider = 8'h18;
  localparam logic [7:0] off_clock_pair_select = 8'h1C;
  localparam logic [7:0] off_scale_b_divider = 8'h20;
  localparam logic [7:0] off_period_base = 8'h40;
  localparam logic [7:0] off_duty_base = 8'h60;
  localparam logic [7:0] off_counter_base = 8'h80;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] prescale_mask = 8'h77;
  localparam logic [7:0] control_mask = 8'hFC;
  localparam int unsigned prescale_a_lsb = 0;
  localparam int unsigned prescale_b_lsb = 4;
  localparam logic [7:0] reset_zero = 8'h00;
  localparam logic [7:0] reset_period = 8'hFF;
  localparam logic [7:0] reset_duty = 8'hFF;

  // Channels whose pair bit 0 picks the A family.
  localparam logic [7:0] a_family_at_zero = 8'h33;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_hold = 3'b010,
    st_resp = 3'b100
  } wr_state_t;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] polarity;
    logic [7:0] clk_select;
    logic [7:0] pair_select;
    logic [7:0] prescale;
    logic [7:0] scale_a;
    logic [7:0] scale_b;
  } pwm_config_t;

endpackage

// *** tb/pwm_cfg_sva.sv ***
// Checker of the modulator bus answers and waveform pins.
// Bound to the top module; sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module pwm_cfg_sva
  import pwm_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Waveform pins
  input wire logic [7:0] pwm_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Bus and pin properties
  // ------------------------------------------------------------
  rd_ready_a: assert property (arready == !rvalid)
    else $error("arready does not follow rvalid");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  wr_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  wr_answer_a: assert property (
    awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write answer late");
  rd_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  rd_error_a: assert property (
    rvalid && rresp == resp_slverr |-> rdata == 32'h0)
    else $error("error read carries data");
  out_reset_a: assert property ($fell(rst) |-> pwm_out == 8'h00)
    else $error("pins not idle after reset");
endmodule

bind pwm_clock_polarity_config pwm_cfg_sva pwm_cfg_sva_inst (.clock, .rst,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid,
  .arready, .rdata, .rresp, .rvalid, .rready, .pwm_out);

`default_nettype wire

// *** tb/pwm_load_model.sv ***
// Load model on the eight waveform pins: counts rises and high cycles.
// Assumes the bench pulses clear for one cycle to open a window.
`timescale 1ns/100ps
`default_nettype none

module pwm_load_model (
  // Clock and window control
  input wire logic clock,
  input wire logic clear,
  // Pins from the modulator
  input wire logic [7:0] pwm_out
);
  logic [7:0] prev;
  logic [15:0] rise [8];
  logic [15:0] high [8];

  always_ff @(posedge clock) begin
    prev <= pwm_out;
    for (int i = 0; i < 8; i++) begin
      rise[i] <= clear ? 16'h0 : rise[i] + 16'(pwm_out[i] & ~prev[i]);
      high[i] <= clear ? 16'h0 : high[i] + 16'(pwm_out[i]);
    end
  end
endmodule

`default_nettype wire

// *** tb/pwm_clock_polarity_config_tb.sv ***
// Self-checking bench for the eight-channel modulator block.
// Assumes the load model and the checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, e); end end

module pwm_clock_polarity_config_tb
  import pwm_cfg_pkg::*;
();
  logic clock, rst, awvalid, wvalid, bready, arvalid, rready, clear;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, pwm_out;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int fails = 0, tests_run = 0, cycles = 0, w;

  pwm_clock_polarity_config pwm_clock_polarity_config_inst (.clock, .rst,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pwm_out);
  pwm_load_model pwm_load_model_inst (.clock, .clear, .pwm_out);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [3:0] s = 4'hF);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(r, resp_okay)
    `CHK(d, e)
  endtask

  // Opens a counting window on the load model after a settling time.
  task automatic measure(input int settle, input int span);
    repeat (settle) @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (span) @(posedge clock);
    #1;
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3F;
    {awvalid, wvalid, bready, arvalid, rready, clear} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rdc(8'(i * 4), 32'h0);
    rdc(off_period_base, 32'hFF);
    rdc(off_duty_base, 32'hFF);
    $display("Reset values test done");
    wr(off_prescale_select, 32'hFFFF_FFFF);
    rdc(off_prescale_select, 32'h77);
    wr(off_modulator_control, 32'hFFFF_FFFF);
    rdc(off_modulator_control, 32'hFC);
    wr(off_output_polarity, 32'h5A, 4'h0);
    rdc(off_output_polarity, 32'h0);
    rd(8'hA4);
    `CHK(r, resp_slverr)
    `CHK(d, 32'h0)
    wr(8'hA4, 32'h1);
    `CHK(r, resp_slverr)
    wr(off_output_polarity, 32'hA5);
    `CHK(r, resp_okay)
    repeat (2) @(posedge clock);
    `CHK(pwm_out, 8'hA5)
    $display("Register access test done");
    wr(off_prescale_select, 32'h10);
    wr(off_modulator_control, 32'h0);
    wr(off_output_polarity, 32'h0F);
    for (int c = 0; c < 8; c++) begin
      wr(off_period_base + 8'(4 * c), 32'h4);
      wr(off_duty_base + 8'(4 * c), 32'h1);
    end
    wr(off_channel_enable, 32'hFF);
    for (int p = 0; p < 2; p++) begin
      wr(off_clock_pair_select, p ? 32'hFF : 32'h0);
      measure(16, 32);
      for (int c = 0; c < 8; c++) begin
        `CHK(pwm_load_model_inst.rise[c], 8 >> (c[1] ^ p[0]))
        `CHK(pwm_load_model_inst.high[c], c < 4 ? 8 : 24)
      end
    end
    $display("Clock family test done");
    wr(off_channel_enable, 32'h01);
    wr(off_clock_pair_select, 32'h0);
    wr(off_prescale_select, 32'h0);
    wr(off_clock_source_select, 32'h01);
    wr(off_period_base, 32'h2);
    wr(off_scale_a_divider, 32'hC8);
    for (int s = 3; s >= 0; s -= 3) begin
      wr(off_scale_a_divider, 32'(s));
      w = 4 * (s ? s : 256);
      measure(2 * w, 4 * w);
      `CHK(pwm_load_model_inst.rise[0], 4)
      `CHK(pwm_load_model_inst.high[0], 2 * w)
    end
    wr(off_clock_pair_select, 32'h01);
    wr(off_scale_b_divider, 32'h2);
    measure(16, 32);
    `CHK(pwm_load_model_inst.rise[0], 4)
    `CHK(pwm_load_model_inst.high[0], 16)
    $display("Scaled clock test done");
    summarize();
  end
endmodule

`default_nettype wire
